// >>> hdl/upp_pkg.sv
// Overview of operation
// - Raise program voltage to enter programming
// - One low chip select pulse programs location
// - Pulse lasts 45 to 55 ms
// - Any address order, one pulse each
// - No voltage change while select low
// - Address, data, voltage set 2 us early
// - Data and voltage held 2 us after
// - Enable may lag select without penalty
package upp_pkg;
    localparam int CLK_MHZ = 250;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;
    localparam logic [DATA_W-1:0] ERASED_BYTE = 8'hff;
    // Read timing in ns, slowest grade
    localparam int SELECT_TO_OUTPUT_NS = 350;
    localparam int ENABLE_TO_OUTPUT_NS = 150;
    localparam int OUTPUT_FLOAT_NS = 130;
    // Programming timing
    localparam int PULSE_WIDTH_MS = 50;
    localparam int SETUP_US = 2;
    localparam int HOLD_US = 2;
    localparam int RECOVERY_US = 2;
    localparam int VERIFY_VALID_US = 1;
    // Cycle counts, least times rounded up
    localparam int ACCESS_CYC = (SELECT_TO_OUTPUT_NS * CLK_MHZ + 999) / 1000 + 1;
    localparam int FLOAT_CYC = (OUTPUT_FLOAT_NS * CLK_MHZ + 999) / 1000 + 1;
    localparam int SETUP_CYC = SETUP_US * CLK_MHZ;
    localparam int HOLD_CYC = HOLD_US * CLK_MHZ;
    localparam int RECOVERY_CYC = RECOVERY_US * CLK_MHZ;
    localparam int VERIFY_CYC = VERIFY_VALID_US * CLK_MHZ + 2;
    localparam int PULSE_CYC = PULSE_WIDTH_MS * 1000 * CLK_MHZ;
    localparam int CNT_W = 24;
    typedef enum logic [1:0] {
        UPP_OP_READ,
        UPP_OP_PROGRAM
    } upp_op_t;
endpackage

// >>> hdl/upp_sync.sv
`timescale 1ns/1ps
`default_nettype none
// Two flop synchroniser for the returned data pins
module upp_sync #(
    parameter int W = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_reg;

    // First stage feeds only the second
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_reg <= '0;
            q <= '0;
        end else begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end
endmodule // upp_sync
`default_nettype wire

// >>> hdl/upp_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
// Host side controller for a clockless UV PROM: reads and programs bytes.
// Separate data in and out pins; an outside buffer joins them at the device
// Limitation: one access at a time, no burst or page mode
module upp_ctrl
    import upp_pkg::*;
#(
    // Program pulse in clocks; a bench may shorten it to save run time
    parameter int PULSE_CYCLES = PULSE_CYC
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Request side
    input wire logic req_valid,
    output logic req_ready,
    input wire upp_pkg::upp_op_t req_op,
    input wire logic [upp_pkg::ADDR_W-1:0] req_addr,
    input wire logic [upp_pkg::DATA_W-1:0] req_wdata,
    // Answer side
    output logic rsp_valid,
    output logic [upp_pkg::DATA_W-1:0] rsp_rdata,
    output logic rsp_verify_ok,
    // Memory pins
    output logic [upp_pkg::ADDR_W-1:0] mem_addr,
    output logic mem_select_n,
    output logic mem_enable_n,
    output logic mem_prog_voltage_en,
    input wire logic [upp_pkg::DATA_W-1:0] mem_data_i,
    output logic [upp_pkg::DATA_W-1:0] mem_data_o,
    output logic mem_data_oe
);
    import upp_pkg::*;

    // Phases of a read, and of program followed by verify
    typedef enum logic [3:0] {
        UPP_IDLE,
        UPP_RD_WAIT,
        UPP_RD_FLOAT,
        UPP_PG_SETUP,
        UPP_PG_PULSE,
        UPP_PG_HOLD,
        UPP_PG_RECOVER,
        UPP_VF_WAIT,
        UPP_VF_FLOAT
    } upp_state_t;

    upp_state_t state_reg;                  // Current phase of the pin sequence
    logic [CNT_W-1:0] cnt_reg;              // Time counter for current phase
    logic [DATA_W-1:0] wdata_reg;           // Byte being programmed
    logic [DATA_W-1:0] data_sync;           // Returned data, synchronised
    logic cnt_done;                         // Current phase has run its course
    logic rd_close;                         // Read window ends this cycle
    logic vf_close;                         // Verify window ends this cycle

    // Counter reaches zero at the last cycle of a phase
    assign cnt_done = (cnt_reg == '0);
    // Only one request at a time; the pins cannot serve two
    assign req_ready = (state_reg == UPP_IDLE);
    // The answer is taken on the very cycle the window closes
    assign rd_close = (state_reg == UPP_RD_WAIT) && cnt_done;
    assign vf_close = (state_reg == UPP_VF_WAIT) && cnt_done;

    // Pin data is asynchronous to core_clk, so it is resynchronised
    // The two cycles of latency here are allowed for in every wait count,
    // so the byte sampled at the end of a window is already settled
    upp_sync #(
        .W(DATA_W)
    ) u_sync (
        .clk(core_clk),
        .rst(rst),
        .d(mem_data_i),
        .q(data_sync)
    );

    // Written byte, kept for the verify compare
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wdata_reg <= ERASED_BYTE;
        end else if (req_valid && req_ready) begin
            wdata_reg <= req_wdata;
        end
    end

    // Answer registers, kept apart from the pin sequencer
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rsp_valid <= 1'b0;              // No answer pending
            rsp_rdata <= ERASED_BYTE;       // Looks like an erased location
            rsp_verify_ok <= 1'b0;
        end else begin
            // Answer strobe lasts a single cycle
            rsp_valid <= rd_close || vf_close;
            if (rd_close) begin
                // Plain read never claims a verify
                rsp_rdata <= data_sync;
                rsp_verify_ok <= 1'b0;
            end else if (vf_close) begin
                // Only ones may turn to zeros, so a mismatch means a failed cell
                rsp_rdata <= data_sync;
                rsp_verify_ok <= (data_sync == wdata_reg);
            end
        end
    end

    // Sequencer and pin drive
    // Voltage only moves while select is high, so no pulse can see it change
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_reg <= UPP_IDLE;
            cnt_reg <= '0;                  // Counter idle
            mem_addr <= '0;
            mem_select_n <= 1'b1;           // Standby: device outputs float
            mem_enable_n <= 1'b1;
            mem_prog_voltage_en <= 1'b0;
            mem_data_o <= ERASED_BYTE;
            mem_data_oe <= 1'b0;            // Host data drivers off
        end else begin
            // Counter runs down to zero and rests there
            if (!cnt_done) begin
                cnt_reg <= cnt_reg - 1'b1;
            end
            // One branch per phase of the pin sequence
            case (state_reg)
                UPP_IDLE: begin
                    // Address and data latch when a request is taken
                    if (req_valid) begin
                        mem_addr <= req_addr;   // Any address order accepted
                        if (req_op == UPP_OP_PROGRAM) begin
                            // Voltage, address, data set up while select is high
                            mem_prog_voltage_en <= 1'b1;
                            mem_enable_n <= 1'b1;
                            mem_data_o <= req_wdata;
                            mem_data_oe <= 1'b1;
                            cnt_reg <= CNT_W'(SETUP_CYC);
                            state_reg <= UPP_PG_SETUP;
                        end else begin
                            // Enable with select; no penalty on access
                            mem_select_n <= 1'b0;
                            mem_enable_n <= 1'b0;
                            cnt_reg <= CNT_W'(ACCESS_CYC + 2);
                            state_reg <= UPP_RD_WAIT;
                        end
                    end
                end
                UPP_RD_WAIT: begin
                    // Answer taken in its own block on this same cycle
                    if (cnt_done) begin
                        mem_select_n <= 1'b1;   // Float timed from first high edge
                        mem_enable_n <= 1'b1;
                        cnt_reg <= CNT_W'(FLOAT_CYC);
                        state_reg <= UPP_RD_FLOAT;
                    end
                end
                UPP_RD_FLOAT: begin
                    // Address held until bus floated, covers zero hold
                    if (cnt_done) begin
                        state_reg <= UPP_IDLE;
                    end
                end
                UPP_PG_SETUP: begin
                    // Select falls only after the setup time has passed,
                    // so address, data and voltage are settled at the edge
                    if (cnt_done) begin
                        mem_select_n <= 1'b0;   // Single pulse per location
                        cnt_reg <= CNT_W'(PULSE_CYCLES);
                        state_reg <= UPP_PG_PULSE;
                    end
                end
                UPP_PG_PULSE: begin
                    // Fixed nominal width inside 45..55 ms, never a DC level
                    if (cnt_done) begin
                        mem_select_n <= 1'b1;
                        cnt_reg <= CNT_W'(HOLD_CYC);
                        state_reg <= UPP_PG_HOLD;
                    end
                end
                UPP_PG_HOLD: begin
                    // Data and voltage held after pulse; voltage drops with select high
                    if (cnt_done) begin
                        mem_prog_voltage_en <= 1'b0;
                        mem_data_oe <= 1'b0;
                        cnt_reg <= CNT_W'(RECOVERY_CYC);
                        state_reg <= UPP_PG_RECOVER;
                    end
                end
                UPP_PG_RECOVER: begin
                    // Recovery before verify read
                    if (cnt_done) begin
                        mem_select_n <= 1'b0;
                        mem_enable_n <= 1'b0;
                        cnt_reg <= CNT_W'(VERIFY_CYC);
                        state_reg <= UPP_VF_WAIT;
                    end
                end
                UPP_VF_WAIT: begin
                    // Verify byte sampled after valid delay
                    if (cnt_done) begin
                        // Both controls rise together, so float starts at once
                        mem_select_n <= 1'b1;
                        mem_enable_n <= 1'b1;
                        cnt_reg <= CNT_W'(FLOAT_CYC);
                        state_reg <= UPP_VF_FLOAT;
                    end
                end
                UPP_VF_FLOAT: begin
                    // Wait for the device to let go of the data pins
                    // before a new request can turn the bus around
                    if (cnt_done) begin
                        state_reg <= UPP_IDLE;
                    end
                end
                default: begin
                    // Unused codes fall back to idle
                    state_reg <= UPP_IDLE;
                end
            endcase
        end
    end
endmodule // upp_ctrl
`default_nettype wire

// >>> tb/upp_prom_model.sv
`timescale 1ns/1ps
`default_nettype none
// Behavioural clockless memory on the far side of the controller
module upp_prom_model
    import upp_pkg::*;
(
    // Control pins
    input wire logic [upp_pkg::ADDR_W-1:0] addr,
    input wire logic select_n,
    input wire logic enable_n,
    input wire logic vpp,
    // Data pins
    input wire logic [upp_pkg::DATA_W-1:0] din,
    output logic [upp_pkg::DATA_W-1:0] dout
);
    logic [DATA_W-1:0] mem [2**ADDR_W];
    logic [DATA_W-1:0] last;
    // Erased array reads all ones
    initial begin
        foreach (mem[i]) mem[i] = ERASED_BYTE;
        // Floating pins then show zeros, unlike any erased byte
        last = 8'hff;
    end
    // Pulse end commits; bits can only be cleared
    always @(posedge select_n) begin
        if (vpp) mem[addr] = mem[addr] & din;
    end
    // Slow grade answer; floats show inverse of last byte
    always @(select_n, enable_n, vpp, addr) begin
        dout = ~last;
        #300;
        if (!select_n && !enable_n && !vpp) begin
            dout = mem[addr];
            last = dout;
        end
    end
endmodule // upp_prom_model
`default_nettype wire

// >>> tb/upp_ctrl_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// Pin timing checks for the controller
module upp_ctrl_asserts
    import upp_pkg::*;
#(
    parameter int PULSE_CYCLES = PULSE_CYC
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Answer
    input wire logic rsp_valid,
    // Memory pins
    input wire logic [upp_pkg::ADDR_W-1:0] mem_addr,
    input wire logic mem_select_n,
    input wire logic mem_enable_n,
    input wire logic mem_prog_voltage_en,
    input wire logic [upp_pkg::DATA_W-1:0] mem_data_o,
    input wire logic mem_data_oe
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    int stab_cnt, rise_cnt, vfall_cnt, low_cnt, pulse_cnt;
    // Cycles since pins moved, since pulse end, since voltage drop; low length; pulses per answer
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            stab_cnt <= 0;
            rise_cnt <= 9999;
            vfall_cnt <= 9999;
            low_cnt <= 0;
            pulse_cnt <= 0;
        end else begin
            stab_cnt <= $stable({mem_addr, mem_data_o, mem_prog_voltage_en}) ? stab_cnt + 1 : 0;
            rise_cnt <= ($rose(mem_select_n) && mem_prog_voltage_en) ? 0 : rise_cnt + 1;
            vfall_cnt <= $fell(mem_prog_voltage_en) ? 0 : vfall_cnt + 1;
            low_cnt <= mem_select_n ? low_cnt : ($past(mem_select_n) ? 1 : low_cnt + 1);
            pulse_cnt <= rsp_valid ? 0 : pulse_cnt + int'($fell(mem_select_n) && mem_prog_voltage_en);
        end
    end
    volt_steady_a: assert property ((!mem_select_n || !$past(mem_select_n)) |-> $stable(mem_prog_voltage_en))
        else $error("program voltage moved while select low");
    pulse_width_a: assert property ($rose(mem_select_n) && mem_prog_voltage_en |->
        low_cnt * 10 >= PULSE_CYCLES * 9 && low_cnt * 10 <= PULSE_CYCLES * 11)
        else $error("program pulse width out of range");
    prog_setup_a: assert property ($fell(mem_select_n) && mem_prog_voltage_en |->
        mem_data_oe && stab_cnt >= SETUP_CYC - 1)
        else $error("program setup too short");
    prog_hold_a: assert property (!$stable({mem_prog_voltage_en, mem_data_oe, mem_data_o}) |->
        rise_cnt >= HOLD_CYC - 1)
        else $error("program hold too short");
    recovery_wait_a: assert property ($fell(mem_enable_n) |-> vfall_cnt >= RECOVERY_CYC - 1)
        else $error("verify read before voltage recovery");
    read_wait_a: assert property (rsp_valid |-> low_cnt >= ACCESS_CYC - 1)
        else $error("answer before access delay");
    enable_lag_a: assert property ($fell(mem_enable_n) |-> !mem_select_n)
        else $error("enable low without select");
    no_fight_a: assert property (!mem_enable_n && !mem_prog_voltage_en |-> !mem_data_oe)
        else $error("host drives data during read");
    one_pulse_a: assert property (rsp_valid |-> pulse_cnt <= 1)
        else $error("more than one pulse per location");
    cover property ($rose(mem_select_n) && mem_prog_voltage_en);
    cover property ($fell(mem_enable_n) && vfall_cnt < 1000);
    cover property (rsp_valid && rise_cnt > 5000);
endmodule // upp_ctrl_asserts
bind upp_ctrl upp_ctrl_asserts #(.PULSE_CYCLES(PULSE_CYCLES)) u_asserts (.core_clk(core_clk), .rst(rst),
    .rsp_valid(rsp_valid), .mem_addr(mem_addr), .mem_select_n(mem_select_n), .mem_enable_n(mem_enable_n),
    .mem_prog_voltage_en(mem_prog_voltage_en), .mem_data_o(mem_data_o), .mem_data_oe(mem_data_oe));
`default_nettype wire

// >>> tb/upp_ctrl_bench.sv
`timescale 1ns/1ps
`default_nettype none
// Reads and programs a behavioural memory through the controller
module upp_ctrl_bench;
    import upp_pkg::*;
    logic core_clk = 0, rst = 1, req_valid = 0, req_ready, rsp_valid, rsp_verify_ok;
    logic sel_n, en_n, vpp, oe;
    upp_op_t req_op = UPP_OP_READ;
    logic [ADDR_W-1:0] req_addr = 12'h000, addr;
    logic [DATA_W-1:0] req_wdata = 8'h00, rsp_rdata, d_i, d_o;
    int err_count = 0, tests_run = 0;
    // Short pulse keeps the run brief
    upp_ctrl #(.PULSE_CYCLES(20)) u_dut (.core_clk(core_clk), .rst(rst), .req_valid(req_valid),
        .req_ready(req_ready), .req_op(req_op), .req_addr(req_addr), .req_wdata(req_wdata),
        .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_verify_ok(rsp_verify_ok), .mem_addr(addr),
        .mem_select_n(sel_n), .mem_enable_n(en_n), .mem_prog_voltage_en(vpp), .mem_data_i(d_i),
        .mem_data_o(d_o), .mem_data_oe(oe));
    upp_prom_model u_mem (.addr(addr), .select_n(sel_n), .enable_n(en_n), .vpp(vpp), .din(d_o), .dout(d_i));
    always #2 core_clk = ~core_clk;
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // One request; waits for idle, then for the answer pulse
    task automatic do_req(input upp_op_t op, input logic [11:0] a, input logic [7:0] d);
        int n;
        n = 0;
        while (req_ready !== 1'b1 && n < 500) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        @(posedge core_clk);
        req_valid <= 1'b1;
        req_op <= op;
        req_addr <= a;
        req_wdata <= d;
        @(posedge core_clk);
        req_valid <= 1'b0;
        n = 0;
        while (rsp_valid !== 1'b1 && n < 5000) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        check("answer", {7'h00, rsp_valid}, 8'h01);
    endtask
    // Both ends of the array read erased
    task automatic t_erased();
        do_req(UPP_OP_READ, 12'h000, 8'h00);
        check("rdata low end", rsp_rdata, ERASED_BYTE);
        do_req(UPP_OP_READ, 12'hfff, 8'h00);
        check("rdata high end", rsp_rdata, ERASED_BYTE);
        $display("test erased done");
    endtask
    // Two locations out of order, verify both, read back the first and its neighbour
    task automatic t_program();
        do_req(UPP_OP_PROGRAM, 12'h5a3, 8'h3c);
        check("verify byte", rsp_rdata, 8'h3c);
        check("verify ok", {7'h00, rsp_verify_ok}, 8'h01);
        do_req(UPP_OP_PROGRAM, 12'h012, 8'ha5);
        check("second verify", rsp_rdata, 8'ha5);
        check("second ok", {7'h00, rsp_verify_ok}, 8'h01);
        do_req(UPP_OP_READ, 12'h5a3, 8'h00);
        check("read back", rsp_rdata, 8'h3c);
        check("read flag", {7'h00, rsp_verify_ok}, 8'h00);
        do_req(UPP_OP_READ, 12'h5a4, 8'h00);
        check("neighbour", rsp_rdata, ERASED_BYTE);
        $display("test program done");
    endtask
    // Programming cannot set a cleared bit
    task automatic t_overwrite();
        do_req(UPP_OP_PROGRAM, 12'h012, 8'h5b);
        check("cleared only", rsp_rdata, 8'h01);
        check("verify fails", {7'h00, rsp_verify_ok}, 8'h00);
        $display("test overwrite done");
    endtask
    // Main sequence
    initial begin
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
        t_erased();
        t_program();
        t_overwrite();
        stop_test();
    end
    // Watchdog well beyond the expected run length
    initial begin
        #200us;
        err_count++;
        stop_test();
    end
endmodule // upp_ctrl_bench
`default_nettype wire
